// file: logic/eep_pkg.sv
// Shared constants and types for the two-wire serial memory target.
// Assumes a single system clock; bus pins arrive unsynchronised.
package eep_pkg;

  // Device-type nibble of the selection word; value is arbitrary
  localparam logic [3:0] EEP_DEVICE_TYPE_DEF = 4'h5;

  // Array geometry
  localparam int EEP_ADDR_W     = 13;    // 8192 byte locations
  localparam int EEP_MEM_DEPTH  = 8192;
  localparam int EEP_PAGE_W     = 5;     // Page offset bits, 32 bytes
  localparam int EEP_FIFO_DEPTH = 32;    // One page of write data
  localparam logic [1:0] EEP_PROT_QUARTER = 2'h3;  // Top two address bits

  // Bit counting per byte
  localparam logic [3:0] EEP_BITS_PER_BYTE = 4'h8;

  // Programming time: 5 ms at the system clock rate
  localparam int EEP_CLK_MHZ        = 20;
  localparam int EEP_PROG_TIME_US   = 5000;
  localparam int EEP_PROG_CYCLES    = EEP_PROG_TIME_US * EEP_CLK_MHZ;
  localparam int EEP_PROG_CNT_W     = 17;

  // Positions of the pins in the synchroniser vector
  localparam int EEP_PIN_SCL  = 0;
  localparam int EEP_PIN_SDA  = 1;
  localparam int EEP_PIN_SEL0 = 2;
  localparam int EEP_PIN_SEL1 = 3;
  localparam int EEP_PIN_SEL2 = 4;
  localparam int EEP_PIN_WP   = 5;
  localparam int EEP_PIN_N    = 6;

  // Transaction states, Gray ordered along the usual path
  typedef enum logic [2:0] {
    EEP_IDLE    = 3'h0,
    EEP_DEVICE  = 3'h1,
    EEP_ACK     = 3'h3,
    EEP_ADDR_HI = 3'h2,
    EEP_ADDR_LO = 3'h6,
    EEP_WDATA   = 3'h7,
    EEP_READ    = 3'h5,
    EEP_RACK    = 3'h4
  } eep_state_type;

  // One buffered write: target location and byte
  typedef struct packed {
    logic [EEP_ADDR_W-1:0] addr;
    logic [7:0]            data;
  } eep_wbyte_type;

  // Whole control state of the target
  typedef struct packed {
    logic [EEP_PIN_N-1:0]      sync1;
    logic [EEP_PIN_N-1:0]      sync2;
    logic                      scl_prev;
    logic                      sda_prev;
    eep_state_type             state;
    eep_state_type             ret_state;
    logic [3:0]                bit_cnt;
    logic [7:0]                shift;
    logic [EEP_ADDR_W-1:0]     addr;
    logic [4:0]                addr_hi;
    logic                      wrote;
    logic                      mack;
    logic                      sda_drive;
    logic                      sda_out;
    logic                      prog_busy;
    logic [EEP_PROG_CNT_W-1:0] prog_cnt;
  } eep_ctrl_type;

  // Value after reset: standby, line released, no programming
  localparam eep_ctrl_type EEP_CTRL_RESET = '0;

endpackage

// file: logic/eep_i2c_target.sv
// Holds the page buffer FIFO and the serial memory target.
// Assumes bus pins and straps are asynchronous to clk_sys and that
// the bus clock is far slower than clk_sys.
`timescale 1ns/1ns

// Page buffer; filled during a write, drained while programming
module eep_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // Pointers carry one extra wrap bit for honest full and empty
  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } eep_fifo_state_type;

  eep_fifo_state_type st;       // Registered pointers
  eep_fifo_state_type next_st;  // Next pointers
  logic [WIDTH-1:0]   buf_mem [DEPTH];  // Storage, no reset needed

  assign in_ready  = (st.wptr ^ st.rptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = st.wptr != st.rptr;
  assign out_data  = buf_mem[st.rptr[AW-1:0]];

  // Pointer update
  always_comb begin
    next_st = st;
    if (in_valid && in_ready) begin
      next_st.wptr = st.wptr + 1'b1;
    end
    if (out_valid && out_ready) begin
      next_st.rptr = st.rptr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage write on accepted push
  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready) begin
      buf_mem[st.wptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// Serial memory target: framing, selection, address, read and write
module eep_i2c_target
  import eep_pkg::*;
#(
  parameter logic [3:0] DEVICE_TYPE = EEP_DEVICE_TYPE_DEF,
  parameter int         PROG_CYCLES = EEP_PROG_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic select_pin_0,
  input  wire logic select_pin_1,
  input  wire logic select_pin_2,
  input  wire logic write_protect,
  output logic      prog_busy
);
  localparam logic [EEP_PROG_CNT_W-1:0] PROG_LAST =
    EEP_PROG_CNT_W'(PROG_CYCLES - 1);

  eep_ctrl_type     st;           // Registered state
  eep_ctrl_type     next_st;      // Next state
  logic [7:0]       mem [EEP_MEM_DEPTH];  // Byte array
  logic [7:0]       rd_data;      // Byte at the address counter
  logic             scl;          // Synchronised bus clock
  logic             sda;          // Synchronised bus data
  logic             scl_rise;     // Bus clock edges
  logic             scl_fall;
  logic             start_cond;   // Framing events
  logic             stop_cond;
  logic             dev_match;    // Selection word matches this part
  logic             prot_hit;     // Current address is protected
  logic             push_valid;   // Buffer write side
  logic             push_ready;
  eep_wbyte_type    push_data;
  logic             drain_valid;  // Buffer drain side
  eep_wbyte_type    drain_data;

  // Synchronised pins; only the second stage is ever looked at
  assign scl = st.sync2[EEP_PIN_SCL];
  assign sda = st.sync2[EEP_PIN_SDA];
  assign scl_rise   = scl & ~st.scl_prev;
  assign scl_fall   = ~scl & st.scl_prev;
  assign start_cond = ~sda & st.sda_prev & scl & st.scl_prev;
  assign stop_cond  = sda & ~st.sda_prev & scl & st.scl_prev;
  // Type nibble, then select code high bit first
  assign dev_match  = st.shift[7:4] == DEVICE_TYPE &&
                      st.shift[3:1] == {st.sync2[EEP_PIN_SEL2],
                                        st.sync2[EEP_PIN_SEL1],
                                        st.sync2[EEP_PIN_SEL0]};
  // Only writes look at protection; reads never do
  assign prot_hit = st.sync2[EEP_PIN_WP] &&
                    st.addr[EEP_ADDR_W-1 -: 2] == EEP_PROT_QUARTER;

  assign sda_out   = st.sda_out;
  assign sda_oe    = st.sda_drive;
  assign prog_busy = st.prog_busy;

  // Next-state logic for the whole transaction engine
  always_comb begin
    next_st = st;
    next_st.sync1 = {write_protect, select_pin_2, select_pin_1,
                     select_pin_0, sda_in, scl_in};
    next_st.sync2 = st.sync1;
    next_st.scl_prev = scl;
    next_st.sda_prev = sda;
    next_st.sda_out = 1'b0;  // Open drain: only ever drives low
    push_valid = 1'b0;
    push_data  = '{addr: st.addr, data: st.shift};

    // Programming timer; busy also waits for the buffer to drain
    if (st.prog_busy) begin
      if (st.prog_cnt >= PROG_LAST && !drain_valid) begin
        next_st.prog_busy = 1'b0;
      end else if (st.prog_cnt < PROG_LAST) begin
        next_st.prog_cnt = st.prog_cnt + 1'b1;
      end
    end

    if (start_cond) begin
      // Any start, repeated or not, reopens selection
      next_st.state   = EEP_DEVICE;
      next_st.bit_cnt = '0;
      next_st.wrote   = 1'b0;
      next_st.sda_drive = 1'b0;
    end else if (stop_cond) begin
      // Stop after data bytes launches programming
      if (st.state == EEP_WDATA && st.wrote && !st.prog_busy) begin
        next_st.prog_busy = 1'b1;
        next_st.prog_cnt  = '0;
      end
      next_st.state = EEP_IDLE;
    end else if (scl_rise) begin
      // Data is taken on the rising clock
      unique case (st.state)
        EEP_DEVICE, EEP_ADDR_HI, EEP_ADDR_LO, EEP_WDATA: begin
          next_st.shift   = {st.shift[6:0], sda};
          next_st.bit_cnt = st.bit_cnt + 1'b1;
        end
        EEP_READ: begin
          next_st.bit_cnt = st.bit_cnt + 1'b1;
        end
        EEP_RACK: begin
          next_st.mack = ~sda;  // Controller pulled low to continue
        end
        EEP_IDLE, EEP_ACK: begin
          next_st.bit_cnt = st.bit_cnt;
        end
      endcase
    end else if (scl_fall) begin
      // Line changes only after the falling clock
      unique case (st.state)
        EEP_DEVICE: begin
          if (st.bit_cnt == EEP_BITS_PER_BYTE) begin
            if (dev_match && !st.prog_busy) begin
              // Acknowledge selection, then read or write
              next_st.sda_drive = 1'b1;
              next_st.state     = EEP_ACK;
              next_st.ret_state = st.shift[0] ? EEP_READ : EEP_ADDR_HI;
            end else begin
              // Wrong part or busy programming
              next_st.state = EEP_IDLE;
            end
          end
        end
        EEP_ADDR_HI: begin
          if (st.bit_cnt == EEP_BITS_PER_BYTE) begin
            // Upper bits above the array are dropped
            next_st.addr_hi   = st.shift[4:0];
            next_st.sda_drive = 1'b1;
            next_st.state     = EEP_ACK;
            next_st.ret_state = EEP_ADDR_LO;
          end
        end
        EEP_ADDR_LO: begin
          if (st.bit_cnt == EEP_BITS_PER_BYTE) begin
            // Sets the counter, also for a dummy write
            next_st.addr      = {st.addr_hi, st.shift};
            next_st.sda_drive = 1'b1;
            next_st.state     = EEP_ACK;
            next_st.ret_state = EEP_WDATA;
          end
        end
        EEP_WDATA: begin
          if (st.bit_cnt == EEP_BITS_PER_BYTE) begin
            // Protected bytes are acked but never buffered
            push_valid = !prot_hit;
            // Only the page offset advances, wrapping
            next_st.addr[EEP_PAGE_W-1:0] =
              st.addr[EEP_PAGE_W-1:0] + 1'b1;
            next_st.wrote     = 1'b1;
            next_st.sda_drive = 1'b1;
            next_st.state     = EEP_ACK;
            next_st.ret_state = EEP_WDATA;
          end
        end
        EEP_ACK: begin
          next_st.bit_cnt = '0;
          next_st.state   = st.ret_state;
          if (st.ret_state == EEP_READ) begin
            // First read bit goes out right after the ack slot
            next_st.shift     = rd_data;
            next_st.sda_drive = ~rd_data[7];
          end else begin
            next_st.sda_drive = 1'b0;  // Release after the ninth clock
          end
        end
        EEP_READ: begin
          if (st.bit_cnt == EEP_BITS_PER_BYTE) begin
            // Release for the controller's ack
            next_st.sda_drive = 1'b0;
            next_st.state     = EEP_RACK;
            next_st.mack      = 1'b0;
            // Full array wrap to zero
            next_st.addr = st.addr + 1'b1;
          end else begin
            next_st.shift     = {st.shift[6:0], 1'b0};
            next_st.sda_drive = ~st.shift[6];
          end
        end
        EEP_RACK: begin
          if (st.mack) begin
            // Ack zero: next byte
            next_st.state     = EEP_READ;
            next_st.bit_cnt   = '0;
            next_st.shift     = rd_data;
            next_st.sda_drive = ~rd_data[7];
          end else begin
            // No ack: stay released until stop or start
            next_st.state = EEP_IDLE;
          end
        end
        EEP_IDLE: begin
          next_st.bit_cnt = st.bit_cnt;
        end
      endcase
    end

    // Standby never holds the line
    if (next_st.state == EEP_IDLE) begin
      next_st.sda_drive = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= EEP_CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Page buffer; drops further bytes once a full page is held
  eep_fifo #(
    .WIDTH ($bits(eep_wbyte_type)),
    .DEPTH (EEP_FIFO_DEPTH)
  ) u_page_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (drain_valid),
    .out_ready (st.prog_busy),
    .out_data  (drain_data)
  );

  // Array: drained only during programming; a full buffer drops later bytes,
  // so the first byte buffered at an offset is the one that lands
  always_ff @(posedge clk_sys) begin
    if (drain_valid && st.prog_busy) begin
      mem[drain_data.addr] <= drain_data.data;
    end
    rd_data <= mem[st.addr];
  end

  property p_never_drive_high;
    @(posedge clk_sys) disable iff (rst) sda_oe |-> !sda_out;
  endproperty
  a_never_drive_high: assert property (p_never_drive_high)
    else $error("data line driven high");

  property p_oe_after_fall;
    @(posedge clk_sys) disable iff (rst)
      $changed(sda_oe) |-> $past(scl_fall) || $past(start_cond) ||
                           $past(stop_cond);
  endproperty
  a_oe_after_fall: assert property (p_oe_after_fall)
    else $error("data line changed away from a falling clock");

  property p_mismatch_nack;
    @(posedge clk_sys) disable iff (rst)
      (st.state == EEP_DEVICE && scl_fall && !start_cond && !stop_cond &&
       st.bit_cnt == EEP_BITS_PER_BYTE && !dev_match)
      |=> st.state == EEP_IDLE && !sda_oe;
  endproperty
  a_mismatch_nack: assert property (p_mismatch_nack)
    else $error("selection mismatch was acknowledged");

  property p_poll_busy;
    @(posedge clk_sys) disable iff (rst)
      (st.state == EEP_DEVICE && scl_fall && !start_cond && !stop_cond &&
       st.bit_cnt == EEP_BITS_PER_BYTE && st.prog_busy)
      |=> !sda_oe [*2];
  endproperty
  a_poll_busy: assert property (p_poll_busy)
    else $error("acknowledged while programming");

  property p_write_ack;
    @(posedge clk_sys) disable iff (rst)
      ((st.state == EEP_ADDR_HI || st.state == EEP_ADDR_LO ||
        st.state == EEP_WDATA) && scl_fall && !start_cond &&
       !stop_cond && st.bit_cnt == EEP_BITS_PER_BYTE)
      |=> sda_oe && st.state == EEP_ACK;
  endproperty
  a_write_ack: assert property (p_write_ack)
    else $error("write byte not acknowledged");

  property p_ack_release;
    @(posedge clk_sys) disable iff (rst)
      (st.state == EEP_ACK && st.ret_state != EEP_READ && scl_fall &&
       !start_cond && !stop_cond) |=> !sda_oe;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("line held after the ack slot");

  property p_page_wrap;
    @(posedge clk_sys) disable iff (rst)
      (st.state == EEP_WDATA && scl_fall && !start_cond && !stop_cond &&
       st.bit_cnt == EEP_BITS_PER_BYTE)
      |=> st.addr[12:5] == $past(st.addr[12:5]) &&
          st.addr[4:0] == $past(st.addr[4:0]) + 5'h01;
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("page offset did not advance within the page");

  property p_protect;
    @(posedge clk_sys) disable iff (rst)
      push_valid |-> !(st.sync2[EEP_PIN_WP] && st.addr[12:11] == 2'h3);
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected byte buffered");

  property p_prog_start;
    @(posedge clk_sys) disable iff (rst)
      $rose(prog_busy) |-> $past(stop_cond) && $past(st.wrote);
  endproperty
  a_prog_start: assert property (p_prog_start)
    else $error("programming started without stop after data");

  property p_ack_bounded;
    @(posedge clk_sys) disable iff (rst)
      (st.state == EEP_RACK || st.state == EEP_IDLE) |-> !sda_oe;
  endproperty
  a_ack_bounded: assert property (p_ack_bounded)
    else $error("line held while waiting for controller");
endmodule

// file: verification/eep_bus_ctrl.sv
// Bus controller model that drives the two-wire clock and data.
// Assumes clk_sys is the bench clock and sda arrives already resolved.
`timescale 1ns/1ns

module eep_bus_ctrl (
  input  wire logic clk_sys,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // Idle bus: clock stands still high, data released
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // One bit, 5 cycles low and 3 high (400 ns); sampled late in high.
  // Far quicker than a real bus to keep the run short; the target only
  // needs a few clk_sys per clock phase
  task automatic clk_bit(input logic b, output logic got);
    @(posedge clk_sys) scl <= 1'b0;
    @(posedge clk_sys) sda_low <= ~b; // Change while low
    repeat (4) @(posedge clk_sys);
    scl <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 got = sda;
  endtask

  // Start: data falls while the clock stands high
  task automatic bus_start();
    @(posedge clk_sys) scl <= 1'b0;
    @(posedge clk_sys) sda_low <= 1'b0; // Long low lets an ack release
    repeat (6) @(posedge clk_sys);
    scl <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sda_low <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  // Stop: data rises while the clock stands high
  task automatic bus_stop();
    @(posedge clk_sys) scl <= 1'b0;
    @(posedge clk_sys) sda_low <= 1'b1;
    repeat (6) @(posedge clk_sys);
    scl <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sda_low <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // Byte out MSB first; ninth clock released for the answer
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], x);
    clk_bit(1'b1, x);
    ack = ~x;
  endtask

  // Byte in MSB first; ninth clock carries our ack or nack
  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(nack, x);
  endtask
endmodule

// file: verification/eep_i2c_target_tb.sv
// Self-checking bench for the two-wire serial memory target.
// Assumes the controller model eep_bus_ctrl and a shortened write time.
`timescale 1ns/1ns

module eep_i2c_target_tb;
  import eep_pkg::*;

  localparam int PROG  = 200;   // Short programming time, drains buffer
  localparam int LIMIT = 60000; // Cycle ceiling for the whole run

  logic       clk_sys = 1'b0;
  logic       rst     = 1'b1;
  logic       wp      = 1'b0;
  logic [2:0] pins    = 3'h0;  // Select straps, pin 2 down to 0
  logic       scl, sda_low, sda_out, sda_oe, prog_busy;
  wire  logic sda = ~((sda_oe & ~sda_out) | sda_low); // Pull-up
  int         bad_count    = 0;
  int         total_checks = 0;
  int         cycles       = 0;
  logic [7:0] ref_mem [EEP_MEM_DEPTH];  // Expected array content

  always #25 clk_sys = ~clk_sys;

  eep_i2c_target #(.PROG_CYCLES(PROG)) i_eep_i2c_target (
    .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_0(pins[0]),
    .select_pin_1(pins[1]), .select_pin_2(pins[2]),
    .write_protect(wp), .prog_busy(prog_busy));

  eep_bus_ctrl i_eep_bus_ctrl (
    .clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));

  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_bit(string what, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk_byte(string what, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic [7:0] sel_word(logic [2:0] s, logic rw);
    return {EEP_DEVICE_TYPE_DEF, s, rw};
  endfunction

  // Start, write selection, two address bytes (junk in unused bits)
  task automatic set_addr(logic [12:0] a);
    logic k;
    i_eep_bus_ctrl.bus_start();
    i_eep_bus_ctrl.send_byte(sel_word(pins, 1'b0), k);
    chk_bit("sel ack", 1'b1, k);
    i_eep_bus_ctrl.send_byte({3'($urandom), a[12:8]}, k);
    chk_bit("hi ack", 1'b1, k);
    i_eep_bus_ctrl.send_byte(a[7:0], k);
    chk_bit("lo ack", 1'b1, k);
  endtask

  // Selection alone, then stop; carries no data so starts nothing
  task automatic poll(output logic k);
    i_eep_bus_ctrl.bus_start();
    i_eep_bus_ctrl.send_byte(sel_word(pins, 1'b0), k);
    i_eep_bus_ctrl.bus_stop();
  endtask

  // Busy after stop, polls refused meanwhile, answered once done
  task automatic wait_prog();
    logic k;
    int   n = 0;
    repeat (2) @(posedge clk_sys);
    #1 chk_bit("busy", 1'b1, prog_busy);
    chk_bit("drive level", 1'b0, sda_out);
    poll(k);
    chk_bit("poll busy", 1'b0, k);
    while (prog_busy === 1'b1 && n < PROG + 100) begin
      @(posedge clk_sys);
      n++;
    end
    chk_bit("busy end", 1'b0, prog_busy);
    poll(k);
    chk_bit("poll done", 1'b1, k);
  endtask

  // Page write; the model wraps the offset and skips locked bytes
  task automatic write_page(logic [12:0] a, int n);
    logic       k;
    logic [7:0] d;
    set_addr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      i_eep_bus_ctrl.send_byte(d, k);
      chk_bit("data ack", 1'b1, k);
      if (!(wp && a[12:11] == EEP_PROT_QUARTER)) begin
        ref_mem[a] = d;
      end
      a[4:0] = a[4:0] + 5'h1;
    end
    i_eep_bus_ctrl.bus_stop();
    wait_prog();
  endtask

  // Read n bytes from the counter; optionally clock on after a nack
  task automatic read_cur(logic [12:0] a, int n, logic more);
    logic       k;
    logic [7:0] d;
    i_eep_bus_ctrl.bus_start();
    i_eep_bus_ctrl.send_byte(sel_word(pins, 1'b1), k);
    chk_bit("read sel ack", 1'b1, k);
    for (int i = 0; i < n; i++) begin
      i_eep_bus_ctrl.recv_byte(i == n - 1, d);
      chk_byte("read data", ref_mem[a], d);
      a = a + 13'h1;
    end
    if (more) begin
      i_eep_bus_ctrl.recv_byte(1'b1, d);
      chk_byte("released", 8'hff, d);
    end
    i_eep_bus_ctrl.bus_stop();
  endtask

  task automatic read_at(logic [12:0] a, int n);
    set_addr(a);
    read_cur(a, n, 1'b0);
  endtask

  initial begin
    logic [12:0] a;
    logic        k;
    int          n;
    void'($urandom(78));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    pins <= 3'($urandom);
    repeat (8) @(posedge clk_sys);
    // Every select code; only the strapped one answers
    for (int c = 0; c < 8; c++) begin
      i_eep_bus_ctrl.bus_start();
      i_eep_bus_ctrl.send_byte(sel_word(3'(c), 1'b0), k);
      chk_bit("select", 3'(c) == pins, k);
      i_eep_bus_ctrl.bus_stop();
    end
    // Wrong type: silent, and stays silent until the next start
    i_eep_bus_ctrl.bus_start();
    i_eep_bus_ctrl.send_byte({~EEP_DEVICE_TYPE_DEF, pins, 1'b0}, k);
    chk_bit("type", 1'b0, k);
    i_eep_bus_ctrl.send_byte(sel_word(pins, 1'b0), k);
    chk_bit("standby", 1'b0, k);
    i_eep_bus_ctrl.bus_stop();
    $display("test select done");
    // Random page writes read back
    for (int t = 0; t < 4; t++) begin
      a = {8'($urandom), 5'($urandom % 24)};
      n = 1 + $urandom % 8;
      write_page(a, n);
      read_at(a, n);
    end
    $display("test random done");
    // Offset wraps at the page end; counter stays in the page. The
    // byte at the counter is written first so the read sees known data
    a = {8'($urandom), 5'h1e};
    write_page({a[12:5], 5'h02}, 1);
    write_page(a, 4);
    read_cur({a[12:5], 5'h02}, 1, 1'b0);
    read_at({a[12:5], 5'h00}, 2);
    $display("test page done");
    // Upper quarter locked while protect is high, readable always
    a = {2'h3, 6'($urandom), 5'h00};
    write_page(a, 4);
    wp <= 1'b1;
    write_page(a, 4);
    read_at(a, 4);
    write_page({2'h2, a[10:0]}, 2);
    read_at({2'h2, a[10:0]}, 2);
    wp <= 1'b0;
    $display("test protect done");
    // Array wrap and a nack with no stop
    write_page(13'h1fff, 1);
    write_page(13'h0000, 1);
    read_at(13'h1fff, 2);
    set_addr(13'h1fff);
    read_cur(13'h1fff, 1, 1'b1);
    $display("test wrap done");
    test_done();
  end
endmodule
